// ### inc/aqs_pkg.sv
// package: constants and types of the conversion and readout sequencer
package aqs_pkg;
  localparam logic [3:0] CODE_LAST = 4'h000B;
  localparam logic [3:0] CODE_ZERO = 4'h0000;
  localparam logic [3:0] UPPER_FIRST_NARROW = 4'h0002;
  localparam logic [3:0] UPPER_FIRST_WIDE = 4'h0006;
  localparam logic [3:0] SHARED_PIN_NARROW = 4'h0003;
  localparam logic [3:0] SHARED_PIN_WIDE = 4'h000B;
  localparam logic [3:0] REPEAT_COUNT = 4'h0008;
  localparam logic [3:0] LEAD_ONES = 4'h000F;
  localparam logic [3:0] STEP_SINGLE = 4'h0001;
  localparam logic [3:0] STEP_DIFF = 4'h0002;
  localparam logic [1:0] SCAN_UP = 2'h0000;
  localparam logic [1:0] SCAN_REPEAT = 2'h0001;
  localparam logic [1:0] SCAN_UPPER = 2'h0002;
  localparam logic [1:0] SCAN_SINGLE = 2'h0003;
  localparam logic [2:0] BIT_LAST = 3'h0007;
  // slave address value is arbitrary
  localparam logic [6:0] ADDR_DEFAULT = 7'h0035;
  localparam int CLK_PERIOD_NS = 100;
  localparam int CONV_LIMIT_NS = 8300;
  // longest time per channel, rounded down to whole cycles
  localparam int CONV_LIMIT_CYC = CONV_LIMIT_NS / CLK_PERIOD_NS;
  localparam logic [6:0] CONV_LIMIT = 7'(CONV_LIMIT_CYC);
  localparam logic [6:0] CONV_MARGIN = 7'h0002;
  typedef enum logic [2:0] {
    LK_IDLE, LK_ADDR, LK_ADDR_ACK, LK_DATA, LK_MACK, LK_IGNORE
  } aqs_link_state_type;
  typedef enum logic [1:0] {SQ_IDLE, SQ_START, SQ_WAIT} aqs_seq_state_type;
  typedef struct packed {
    logic valid;
    logic odd;
    logic [3:0] first;
    logic [3:0] last;
    logic [3:0] step;
    logic [3:0] count;
  } aqs_plan_type;
endpackage

// ### verilog/aqs_sequencer.sv
// sequencer: serial read slave, scan planning, conversion control, result memory
`timescale 1ns/1ps
`default_nettype none

module aqs_sequencer #(
  parameter int NUM_CH = 12,
  parameter logic [6:0] SLAVE_ADDR = aqs_pkg::ADDR_DEFAULT
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic scl_clk,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic chan_sel_bit3,
  input wire logic chan_sel_bit2,
  input wire logic chan_sel_bit1,
  input wire logic chan_sel_bit0,
  input wire logic single_vs_differential,
  input wire logic ref_pin_select,
  input wire logic scan_type_hi,
  input wire logic scan_type_lo,
  input wire logic ext_clock_mode,
  output logic adc_start,
  output logic [3:0] adc_pos_sel,
  output logic [3:0] adc_neg_sel,
  output logic adc_pos_is_gnd,
  output logic adc_neg_is_gnd,
  input wire logic adc_done,
  input wire logic [11:0] adc_result,
  output logic scan_busy,
  output logic [3:0] results_count
);

  // ----------------------------------------
  // variant constants
  // ----------------------------------------
  localparam logic [3:0] DEPTH = 4'(NUM_CH);
  localparam logic SHARE_EXISTS = (NUM_CH != 8);
  localparam logic [3:0] SHARED_PIN = (NUM_CH <= 4) ? aqs_pkg::SHARED_PIN_NARROW :
                                                       aqs_pkg::SHARED_PIN_WIDE;
  localparam logic [3:0] UPPER_FIRST = (NUM_CH <= 4) ? aqs_pkg::UPPER_FIRST_NARROW :
                                                        aqs_pkg::UPPER_FIRST_WIDE;

  // ----------------------------------------
  // state types
  // ----------------------------------------
  typedef struct packed {
    aqs_pkg::aqs_seq_state_type state;
    logic ext_mode;
    logic single;
    logic share_on;
    aqs_pkg::aqs_plan_type plan;
    logic [3:0] cur;
    logic [3:0] done;
    logic [3:0] wr;
    logic [6:0] timer;
    logic stretch;
    logic start;
    logic [3:0] pos;
    logic [3:0] neg;
    logic pos_gnd;
    logic neg_gnd;
    logic [NUM_CH-1:0][11:0] mem;
    logic [3:0] stored;
    logic [11:0] live;
    logic req_meta;
    logic req_sync;
    logic req_seen;
    logic nxt_meta;
    logic nxt_sync;
    logic nxt_seen;
  } aqs_sys_type;

  typedef struct packed {
    logic sda_hi;
    logic rst_meta;
    logic rst_q;
  } aqs_rise_type;

  typedef struct packed {
    aqs_pkg::aqs_link_state_type state;
    logic [2:0] cnt;
    logic [7:0] shreg;
    logic bsel;
    logic [3:0] rd_ptr;
    logic req_tgl;
    logic nxt_tgl;
  } aqs_fall_type;

  aqs_sys_type sys_q;
  aqs_sys_type sys_d;
  aqs_rise_type lr_q;
  aqs_rise_type lr_d;
  aqs_fall_type lf_q;
  aqs_fall_type lf_d;

  // ----------------------------------------
  // functions
  // ----------------------------------------
  // turn channel select, mode and scan field into a conversion plan
  function automatic aqs_pkg::aqs_plan_type make_plan(
    input logic [3:0] cs_raw,
    input logic single,
    input logic share_on,
    input logic [1:0] scan
  );
    aqs_pkg::aqs_plan_type p;
    logic [3:0] cs;
    logic [3:0] top;
    cs = cs_raw;
    if (NUM_CH <= 4) begin
      cs[3:2] = 2'h0000;
    end else if (NUM_CH <= 8) begin
      cs[3] = 1'b0;
    end
    p.valid = (cs <= aqs_pkg::CODE_LAST);
    p.odd = !single && cs[0];
    p.step = single ? aqs_pkg::STEP_SINGLE : aqs_pkg::STEP_DIFF;
    p.first = single ? cs : {cs[3:1], 1'b0};
    p.last = p.first;
    p.count = 4'h0001;
    top = (cs > UPPER_FIRST) ? cs : UPPER_FIRST;
    case (scan)
      aqs_pkg::SCAN_UP: begin
        p.first = aqs_pkg::CODE_ZERO;
        if (single && share_on && cs == SHARED_PIN) begin
          p.last = cs - 4'h0001;
        end
      end
      aqs_pkg::SCAN_UPPER: begin
        p.first = UPPER_FIRST;
        p.last = single ? top : {top[3:1], 1'b0};
        if (single && share_on && top == SHARED_PIN) begin
          p.last = top - 4'h0001;
        end
      end
      aqs_pkg::SCAN_REPEAT: begin
        p.count = aqs_pkg::REPEAT_COUNT;
        if (single && share_on && cs == SHARED_PIN) begin
          p.valid = 1'b0;
        end
      end
      default: begin
        if (single && share_on && cs == SHARED_PIN) begin
          p.valid = 1'b0;
        end
      end
    endcase
    if (scan != aqs_pkg::SCAN_REPEAT) begin
      p.count = single ? (p.last - p.first + 4'h0001) :
                         (((p.last - p.first) >> 1) + 4'h0001);
    end
    return p;
  endfunction

  // next channel address in a scan, wrapping at the limit
  function automatic logic [3:0] next_code(
    input logic [3:0] cur,
    input aqs_pkg::aqs_plan_type p
  );
    return (cur >= p.last) ? p.first : cur + p.step;
  endfunction

  // ----------------------------------------
  // system domain: planning, conversion, memory
  // ----------------------------------------
  logic req_edge;
  logic nxt_edge;
  logic [3:0] code;
  logic [3:0] partner;
  aqs_pkg::aqs_plan_type plan_new;

  assign req_edge = sys_q.req_sync ^ sys_q.req_seen;
  assign nxt_edge = sys_q.nxt_sync ^ sys_q.nxt_seen;
  assign code = sys_q.cur | {3'h0000, sys_q.plan.odd};
  assign partner = code ^ 4'h0001;
  assign plan_new = make_plan({chan_sel_bit3, chan_sel_bit2, chan_sel_bit1,
                               chan_sel_bit0}, single_vs_differential,
                              ref_pin_select && SHARE_EXISTS,
                              {scan_type_hi, scan_type_lo});

  // next state of the conversion sequencer
  always_comb begin
    sys_d = sys_q;
    sys_d.req_meta = lf_q.req_tgl;
    sys_d.req_sync = sys_q.req_meta;
    sys_d.req_seen = sys_q.req_sync;
    sys_d.nxt_meta = lf_q.nxt_tgl;
    sys_d.nxt_sync = sys_q.nxt_meta;
    sys_d.nxt_seen = sys_q.nxt_sync;
    sys_d.start = 1'b0;
    case (sys_q.state)
      aqs_pkg::SQ_IDLE: begin
        if (req_edge) begin
          // new read address: take a fresh configuration
          sys_d.ext_mode = ext_clock_mode;
          sys_d.single = single_vs_differential;
          sys_d.share_on = ref_pin_select && SHARE_EXISTS;
          sys_d.plan = plan_new;
          sys_d.cur = plan_new.first;
          sys_d.done = 4'h0000;
          sys_d.wr = 4'h0000;
          if (plan_new.valid) begin
            sys_d.stretch = !ext_clock_mode;
            sys_d.state = aqs_pkg::SQ_START;
          end
        end else if (nxt_edge && sys_q.ext_mode && sys_q.plan.valid) begin
          sys_d.cur = next_code(sys_q.cur, sys_q.plan);
          sys_d.state = aqs_pkg::SQ_START;
        end
      end
      aqs_pkg::SQ_START: begin
        // route the inputs and fire one conversion
        sys_d.start = 1'b1;
        sys_d.timer = 7'h0000;
        sys_d.pos = code;
        sys_d.neg = partner;
        sys_d.pos_gnd = sys_q.share_on && !sys_q.single && code == SHARED_PIN;
        sys_d.neg_gnd = sys_q.single ||
                        (sys_q.share_on && partner == SHARED_PIN);
        sys_d.state = aqs_pkg::SQ_WAIT;
      end
      aqs_pkg::SQ_WAIT: begin
        sys_d.timer = sys_q.timer + 7'h0001;
        if (adc_done || sys_q.timer == aqs_pkg::CONV_LIMIT - aqs_pkg::CONV_MARGIN) begin
          // timeout bounds the stretch per channel
          if (sys_q.ext_mode) begin
            sys_d.live = adc_result;
            sys_d.state = aqs_pkg::SQ_IDLE;
          end else begin
            sys_d.mem[sys_q.wr] = adc_result;
            sys_d.wr = (sys_q.wr == DEPTH - 4'h0001) ? 4'h0000 : sys_q.wr + 4'h0001;
            sys_d.done = sys_q.done + 4'h0001;
            sys_d.cur = next_code(sys_q.cur, sys_q.plan);
            if (sys_q.done + 4'h0001 == sys_q.plan.count) begin
              sys_d.stored = (sys_q.plan.count > DEPTH) ? DEPTH : sys_q.plan.count;
              sys_d.stretch = 1'b0;
              sys_d.state = aqs_pkg::SQ_IDLE;
            end else begin
              sys_d.state = aqs_pkg::SQ_START;
            end
          end
        end
      end
      default: begin
        sys_d.state = aqs_pkg::SQ_IDLE;
      end
    endcase
    if (reset) begin
      sys_d = '0;
      sys_d.state = aqs_pkg::SQ_IDLE;
      sys_d.single = 1'b1;
    end
  end

  // register the system state
  always_ff @(posedge clk) begin
    sys_q <= sys_d;
  end

  // ----------------------------------------
  // link domain, rising edge: data sample and reset sync
  // ----------------------------------------
  always_comb begin
    lr_d.sda_hi = sda_in;
    lr_d.rst_meta = reset;
    lr_d.rst_q = lr_q.rst_meta;
  end

  // register the rising edge samples
  always_ff @(posedge scl_clk) begin
    lr_q <= lr_d;
  end

  // ----------------------------------------
  // link domain, falling edge: byte framing
  // ----------------------------------------
  logic start_seen;

  // data high at the rise and low at the fall is a start condition
  assign start_seen = lr_q.sda_hi && !sda_in;

  // next state of the serial slave
  always_comb begin
    lf_d = lf_q;
    if (lr_q.rst_q) begin
      lf_d = '0;
      lf_d.state = aqs_pkg::LK_IDLE;
    end else if (start_seen || (lf_q.state == aqs_pkg::LK_IDLE && !sda_in)) begin
      lf_d.state = aqs_pkg::LK_ADDR;
      lf_d.cnt = 3'h0000;
    end else begin
      case (lf_q.state)
        aqs_pkg::LK_ADDR: begin
          lf_d.shreg = {lf_q.shreg[6:0], lr_q.sda_hi};
          lf_d.cnt = lf_q.cnt + 3'h0001;
          if (lf_q.cnt == aqs_pkg::BIT_LAST) begin
            // only a read of this address is answered
            if (lf_q.shreg[6:0] == SLAVE_ADDR && lr_q.sda_hi) begin
              lf_d.state = aqs_pkg::LK_ADDR_ACK;
            end else begin
              lf_d.state = aqs_pkg::LK_IGNORE;
            end
          end
        end
        aqs_pkg::LK_ADDR_ACK: begin
          // ninth falling edge: request a new scan
          lf_d.req_tgl = !lf_q.req_tgl;
          lf_d.state = aqs_pkg::LK_DATA;
          lf_d.cnt = 3'h0000;
          lf_d.bsel = 1'b0;
          lf_d.rd_ptr = 4'h0000;
        end
        aqs_pkg::LK_DATA: begin
          lf_d.cnt = lf_q.cnt + 3'h0001;
          if (lf_q.cnt == aqs_pkg::BIT_LAST) begin
            lf_d.state = aqs_pkg::LK_MACK;
          end
        end
        aqs_pkg::LK_MACK: begin
          if (!lr_q.sda_hi) begin
            lf_d.state = aqs_pkg::LK_DATA;
            lf_d.cnt = 3'h0000;
            lf_d.bsel = !lf_q.bsel;
            if (lf_q.bsel) begin
              // whole result taken: next one, wrapping
              lf_d.nxt_tgl = !lf_q.nxt_tgl;
              lf_d.rd_ptr = (lf_q.rd_ptr + 4'h0001 >= sys_q.stored) ? 4'h0000 :
                            lf_q.rd_ptr + 4'h0001;
            end
          end else begin
            lf_d.state = aqs_pkg::LK_IDLE;
          end
        end
        default: begin
          lf_d.state = lf_q.state;
        end
      endcase
    end
  end

  // register the framing state
  always_ff @(negedge scl_clk) begin
    lf_q <= lf_d;
  end

  // ----------------------------------------
  // pins and status
  // ----------------------------------------
  logic [15:0] tx_word;
  logic [3:0] tx_idx;

  // memory only changes while the clock is held, so it is stable here
  assign tx_word = {aqs_pkg::LEAD_ONES, sys_q.ext_mode ? sys_q.live :
                                         sys_q.mem[lf_q.rd_ptr]};
  assign tx_idx = {!lf_q.bsel, ~lf_q.cnt};
  assign sda_out = 1'b0;
  assign scl_out = 1'b0;
  assign sda_oe_n = !(lf_q.state == aqs_pkg::LK_ADDR_ACK ||
                      (lf_q.state == aqs_pkg::LK_DATA && !tx_word[tx_idx]));
  assign scl_oe_n = !sys_q.stretch;
  assign adc_start = sys_q.start;
  assign adc_pos_sel = sys_q.pos;
  assign adc_neg_sel = sys_q.neg;
  assign adc_pos_is_gnd = sys_q.pos_gnd;
  assign adc_neg_is_gnd = sys_q.neg_gnd;
  assign scan_busy = (sys_q.state != aqs_pkg::SQ_IDLE);
  assign results_count = sys_q.stored;

endmodule

`default_nettype wire

// ### bench/aqs_sequencer_assertions.sv
// checker: port timing relations of the conversion and readout sequencer
`timescale 1ns/1ps
`default_nettype none
module aqs_checker #(
  parameter int NUM_CH = 12
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic scl_oe_n,
  input wire logic adc_start,
  input wire logic [3:0] adc_pos_sel,
  input wire logic [3:0] adc_neg_sel,
  input wire logic adc_pos_is_gnd,
  input wire logic adc_neg_is_gnd,
  input wire logic scan_busy,
  input wire logic [3:0] results_count
);
  localparam int STRETCH_MAX = 90;
  logic [7:0] wait_q;
  logic [7:0] wait_d;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // cycles held stretched since the last conversion start
  always_comb begin
    wait_d = wait_q + 8'h01;
    if (adc_start || scl_oe_n) begin
      wait_d = 8'h00;
    end
  end
  // counter register
  always_ff @(posedge clk) begin
    if (reset) begin
      wait_q <= 8'h00;
    end else begin
      wait_q <= wait_d;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  AST_STRETCH_BOUND: assert property (int'(wait_q) <= STRETCH_MAX)
    else $error("stretch too long for one conversion");
  AST_START_PULSE: assert property (adc_start |=> !adc_start)
    else $error("conversion start longer than one cycle");
  AST_START_BUSY: assert property (adc_start |-> ##[0:1] scan_busy)
    else $error("conversion started outside a sequence");
  AST_SEL_HOLD: assert property (!adc_start |->
    $stable({adc_pos_sel, adc_neg_sel, adc_pos_is_gnd, adc_neg_is_gnd}))
    else $error("input routing changed between starts");
  AST_PAIR_ADJACENT: assert property (adc_start && !adc_pos_is_gnd
    && !adc_neg_is_gnd |-> (adc_pos_sel ^ adc_neg_sel) == 4'h1)
    else $error("differential pair not adjacent");
  AST_CODE_RANGE: assert property (adc_start && !adc_pos_is_gnd
    |-> int'(adc_pos_sel) < NUM_CH)
    else $error("positive input beyond the variant");
  AST_COUNT_DEPTH: assert property (int'(results_count) <= NUM_CH)
    else $error("result count beyond memory depth");
  AST_RELEASE_DONE: assert property ($rose(scl_oe_n) |-> ##[0:2] !scan_busy)
    else $error("clock released while still converting");
endmodule
bind aqs_sequencer aqs_checker #(.NUM_CH(NUM_CH)) u_checker (
  .clk(clk), .reset(reset), .scl_oe_n(scl_oe_n), .adc_start(adc_start),
  .adc_pos_sel(adc_pos_sel), .adc_neg_sel(adc_neg_sel),
  .adc_pos_is_gnd(adc_pos_is_gnd), .adc_neg_is_gnd(adc_neg_is_gnd),
  .scan_busy(scan_busy), .results_count(results_count));
`default_nettype wire

// ### bench/aqs_master_model.sv
// serial bus master model: start, address byte, result bytes, acknowledge
`timescale 1ns/1ps
`default_nettype none
module aqs_master_model (
  output logic scl_m,
  output logic sda_m,
  input wire logic scl_w,
  input wire logic sda_w
);
  // clock idles low, data released
  initial begin
    scl_m = 1'b0;
    sda_m = 1'b1;
  end
  // one pulse, waits out stretching, samples at the rise
  task automatic pulse(output logic b);
    #10 scl_m = 1'b1;
    wait (scl_w === 1'b1);
    b = sda_w;
    #15 scl_m = 1'b0;
    #5;
  endtask
  // idle pulses with data released
  task automatic pulses(input int n);
    logic b;
    repeat (n) pulse(b);
  endtask
  // start: data falls while clock high
  task automatic start();
    sda_m = 1'b1;
    #10 scl_m = 1'b1;
    #8 sda_m = 1'b0;
    #7 scl_m = 1'b0;
    #5;
  endtask
  // address byte msb first, then sample acknowledge
  task automatic put_byte(input logic [7:0] v, output logic ak);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      sda_m = v[i];
      pulse(b);
    end
    sda_m = 1'b1;
    pulse(b);
    ak = ~b;
  endtask
  // read byte msb first, then acknowledge or refuse
  task automatic get_byte(output logic [7:0] v, input logic more);
    logic b;
    sda_m = 1'b1;
    for (int i = 0; i < 8; i++) begin
      pulse(b);
      v = {v[6:0], b};
    end
    sda_m = ~more;
    pulse(b);
    sda_m = 1'b1;
  endtask
endmodule
`default_nettype wire

// ### bench/adc_i2c_read_and_conversion_sequencer_bench.sv
// bench: serial reads of the sequencer with a converter model
`timescale 1ns/1ps
`default_nettype none
module adc_i2c_read_and_conversion_sequencer_bench;
  localparam logic [6:0] AD = aqs_pkg::ADDR_DEFAULT;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic scl_m, sda_m, scl_w, sda_w, scl_oe_n, sda_oe_n, ak;
  logic scl_o, sda_o;
  logic adc_start, adc_pos_is_gnd, adc_neg_is_gnd, scan_busy;
  logic sg = 1'b1, rs = 1'b0, ex = 1'b0, adc_done = 1'b0, pend = 1'b0;
  logic [1:0] sc = 2'h3;
  logic [3:0] cs = 4'h0, conv_n = 4'h0, kb = 4'h0;
  logic [3:0] adc_pos_sel, adc_neg_sel, results_count, ep[12], en[12];
  logic [11:0] adc_result = 12'h000;
  logic [15:0] got[12];
  int num_errors = 0, n_compared = 0, lat = 3, wt = 0, cyc = 0;
  always #50 clk = ~clk;
  // wired lines with pull-ups
  assign scl_w = scl_m & scl_oe_n;
  assign sda_w = sda_m & sda_oe_n;
  aqs_sequencer #(.NUM_CH(12)) DUT (
    .clk(clk), .reset(reset), .scl_clk(scl_w), .scl_out(scl_o), .scl_oe_n(scl_oe_n),
    .sda_in(sda_w), .sda_out(sda_o), .sda_oe_n(sda_oe_n), .chan_sel_bit3(cs[3]),
    .chan_sel_bit2(cs[2]), .chan_sel_bit1(cs[1]), .chan_sel_bit0(cs[0]),
    .single_vs_differential(sg), .ref_pin_select(rs), .scan_type_hi(sc[1]),
    .scan_type_lo(sc[0]), .ext_clock_mode(ex), .adc_start(adc_start),
    .adc_pos_sel(adc_pos_sel), .adc_neg_sel(adc_neg_sel), .adc_pos_is_gnd(adc_pos_is_gnd),
    .adc_neg_is_gnd(adc_neg_is_gnd), .adc_done(adc_done), .adc_result(adc_result),
    .scan_busy(scan_busy), .results_count(results_count));
  aqs_master_model u_m (.scl_m(scl_m), .sda_m(sda_m), .scl_w(scl_w), .sda_w(sda_w));
  // converter model: result tags route and start number, done after lat
  always @(posedge clk) begin
    adc_done <= 1'b0;
    if (adc_start === 1'b1) begin
      adc_result <= {adc_pos_is_gnd ? 4'hF : adc_pos_sel,
                     adc_neg_is_gnd ? 4'hF : adc_neg_sel, conv_n};
      conv_n <= conv_n + 4'h1;
      wt <= lat;
      pend <= 1'b1;
    end else if (pend) begin
      wt <= wt - 1;
      if (wt == 0) begin
        adc_done <= 1'b1;
        pend <= 1'b0;
      end
    end
  end
  // cycle ceiling against a hung bus
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      summarize();
    end
  end
  task automatic summarize();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one read frame: request, address, nrd results, last one refused
  task automatic frame(input logic [6:0] ad, input logic [1:0] s, input logic [3:0] c,
      input logic g, input logic r, input logic x, input int nrd);
    @(posedge clk);
    sc <= s;
    cs <= c;
    sg <= g;
    rs <= r;
    ex <= x;
    @(posedge clk);
    u_m.start();
    u_m.put_byte({ad, 1'b1}, ak);
    #1500;
    for (int i = 0; i < nrd; i++) begin
      u_m.get_byte(got[i][15:8], 1'b1);
      u_m.get_byte(got[i][7:0], i < nrd - 1);
    end
  endtask
  // planned routes: n entries stepping from p0 and n0
  task automatic fill(input int n, input int p0, input int ps, input int n0, input int ns);
    kb = conv_n;
    for (int i = 0; i < n; i++) begin
      ep[i] = 4'(p0 + i * ps);
      en[i] = 4'(n0 + i * ns);
    end
  endtask
  // read words against the plan, wrapping after n entries
  task automatic expect_list(input int n, input int rd);
    for (int i = 0; i < rd; i++)
      chk("result", {4'hF, ep[i % n], en[i % n], kb + 4'(i % n)}, got[i]);
    chk("count", 16'(n), {12'h000, results_count});
    chk("conversions", 16'(n), {12'h000, conv_n - kb});
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk("idle", 16'h000F, {12'h000, scl_oe_n, sda_oe_n, ~adc_start, ~scan_busy});
    chk("count", 16'h0000, {12'h000, results_count});
    chk("open drain", 16'h0000, {14'h0000, scl_o, sda_o});
  endtask
  task automatic t_bad_address();
    frame(AD ^ 7'h01, 2'h3, 4'h0, 1'b1, 1'b0, 1'b0, 0);
    chk("bad ack", 16'h0000, {15'h0000, ak});
    chk("bad conv", 16'h0000, {12'h000, conv_n});
  endtask
  task automatic t_single_slow();
    lat = 60;
    fill(1, 5, 0, 15, 0);
    frame(AD, 2'h3, 4'h5, 1'b1, 1'b0, 1'b0, 2);
    chk("ack", 16'h0001, {15'h0000, ak});
    expect_list(1, 2);
    // converter too slow: the per-channel bound ends the stretch
    lat = 200;
    fill(1, 5, 0, 15, 0);
    frame(AD, 2'h3, 4'h5, 1'b1, 1'b0, 1'b0, 1);
    expect_list(1, 1);
    lat = 3;
  endtask
  task automatic t_scans();
    fill(5, 0, 1, 15, 0);
    frame(AD, 2'h0, 4'h4, 1'b1, 1'b0, 1'b0, 6);
    expect_list(5, 6);
    fill(11, 0, 1, 15, 0);
    frame(AD, 2'h0, 4'hB, 1'b1, 1'b1, 1'b0, 11);
    expect_list(11, 11);
    fill(4, 1, 2, 0, 2);
    frame(AD, 2'h0, 4'h7, 1'b0, 1'b0, 1'b0, 4);
    expect_list(4, 4);
    fill(1, 15, 0, 10, 0);
    frame(AD, 2'h3, 4'hB, 1'b0, 1'b1, 1'b0, 1);
    expect_list(1, 1);
    fill(8, 2, 0, 15, 0);
    frame(AD, 2'h1, 4'h2, 1'b1, 1'b0, 1'b0, 8);
    expect_list(8, 8);
    fill(3, 6, 1, 15, 0);
    frame(AD, 2'h2, 4'h8, 1'b1, 1'b0, 1'b0, 3);
    expect_list(3, 3);
  endtask
  task automatic t_ignored();
    frame(AD, 2'h3, 4'hC, 1'b1, 1'b0, 1'b0, 1);
    expect_list(3, 1);
    frame(AD, 2'h3, 4'hB, 1'b1, 1'b1, 1'b0, 1);
    expect_list(3, 1);
  endtask
  task automatic t_external();
    for (int s = 1; s < 4; s += 2) begin
      kb = conv_n;
      frame(AD, 2'(s), 4'h3, 1'b1, 1'b0, 1'b1, 2);
      // let the conversion requested by the last ack land
      repeat (12) @(posedge clk);
      chk("ext first", {8'hF3, 4'hF, kb}, got[0]);
      chk("ext route", 16'hF3F0, got[1] & 16'hFFF0);
      chk("ext conv", 16'h0002, {12'h000, conv_n - kb});
    end
  endtask
  // main sequence
  initial begin
    u_m.pulses(4);
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    // idle clocks flush the link side reset synchroniser
    u_m.pulses(2);
    t_reset();
    t_bad_address();
    t_single_slow();
    t_scans();
    t_ignored();
    t_external();
    summarize();
  end
endmodule
`default_nettype wire
